// [rtl/ipr_pending.sv]
/*
 * Interrupt pending register with its level control and external-line
 * mode registers, reached over classic Wishbone.
 * Assumes active-low asynchronous pins and level-high internal sources.
 */
`timescale 1ns/100ps
module ipr_pending
    import ipr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  emu_break,
    input  wire logic        emulator_request_pin_b,
    input  wire logic        periodic_tick_pending,
    input  wire logic        spi1_irq,
    input  wire logic        spi2_irq,
    input  wire logic        pwm1_irq,
    input  wire logic        pwm2_irq,
    input  wire logic        uart1_irq,
    input  wire logic        uart2_irq,
    input  wire logic        keyboard_pending,
    input  wire logic        timer_one_pending,
    input  wire logic        timer_two_pending,
    input  wire logic        rtc_irq,
    input  wire logic        watchdog_pending,
    input  wire logic        ext_request_l5_b,
    input  wire logic        ext_request_l6_b,
    input  wire logic        ext_request_l3_b,
    input  wire logic        ext_request_l2_b,
    input  wire logic        ext_request_l1_b,
    input  wire logic [3:0]  key_line_b,
    input  wire logic        emu_clear,
    output logic      [31:0] interrupt_pending,
    output logic      [2:0]  top_level
);

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] emu_sync;
        logic [N_EXT-1:0]      ext_s1;
        logic [N_EXT-1:0]      ext_s2;
        logic [N_EXT-1:0]      ext_s3;
        logic                  emu_pend;
        logic [N_EXT-1:0]      edge_pend;
        logic [15:0]           level_cfg;
        logic [N_EXT-1:0]      mode_edge;
        logic [31:0]           pend;
        logic [2:0]            top;
        logic [31:0]           rdat;
        logic                  ack;
    } ipr_state_t;

    ipr_state_t st_ff;
    ipr_state_t nxt_st;

    // Pin vector in pending-bit order: l5,l6,l3,l2,l1 then key3..key0
    logic [N_EXT-1:0] pin_b;
    assign pin_b = {ext_request_l5_b, ext_request_l6_b, ext_request_l3_b,
                    ext_request_l2_b, ext_request_l1_b, key_line_b};

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Largest of two level codes, by raw code value
    function automatic logic [2:0] lvl_max(input logic [2:0] a, input logic [2:0] b);
        return (a > b) ? a : b;
    endfunction

    logic        req;
    logic        wr_acc;
    logic [31:0] wmask;
    logic [31:0] pend_now;
    logic [31:0] lvl_merged;
    logic [31:0] mode_merged;
    logic        clr_seen;

    // Merged words kept whole; a function result cannot be part-selected
    always_comb begin
        req         = wb_cyc_i && wb_stb_i && !st_ff.ack;
        wr_acc      = req && wb_we_i;
        wmask       = merge(32'h0000_0000, 32'hffff_ffff, wb_sel_i);
        lvl_merged  = merge({16'h0000, st_ff.level_cfg}, wb_dat_i, wb_sel_i);
        mode_merged = merge({23'h0, st_ff.mode_edge}, wb_dat_i, wb_sel_i);
    end

    // Software clear of the level-5 edge flag in this cycle
    assign clr_seen = wr_acc && wb_adr_i == ADR_PENDING && wb_dat_i[BIT_L5] && wb_sel_i[2];

    // Next-state logic for the whole block
    always_comb begin
        logic [N_EXT-1:0] fell;
        logic [N_EXT-1:0] asserted;
        logic [N_EXT-1:0] clr;
        logic             emu_fell;
        logic [2:0]       t;
        nxt_st   = st_ff;
        t        = 3'h0;
        fell     = '0;
        asserted = '0;
        clr      = '0;
        emu_fell = 1'b0;
        // Three-flop sync; first flop feeds only the second
        nxt_st.ext_s1   = pin_b;
        nxt_st.ext_s2   = st_ff.ext_s1;
        nxt_st.ext_s3   = st_ff.ext_s2;
        nxt_st.emu_sync = {st_ff.emu_sync[SYNC_DEPTH-2:0], emulator_request_pin_b};
        // Edge seen while stage two holds the new value and stage three still the old one
        fell     = st_ff.ext_s3 & ~st_ff.ext_s2;
        asserted = ~st_ff.ext_s3;
        emu_fell = st_ff.emu_sync[2] && !st_ff.emu_sync[1];
        clr      = '0;
        if (wr_acc && wb_adr_i == ADR_PENDING) begin
            clr[8:4] = wb_dat_i[BIT_L5:BIT_L1] & wmask[BIT_L5:BIT_L1];
        end
        if (wr_acc && wb_adr_i == ADR_KEYCLR) begin
            clr[3:0] = wb_dat_i[3:0] & wmask[3:0];
        end
        // Set beats clear on the same cycle
        nxt_st.edge_pend = ((st_ff.edge_pend & ~clr) | fell) & st_ff.mode_edge;
        // Emulator flag held until the emulation status side clears it
        nxt_st.emu_pend = (st_ff.emu_pend && !emu_clear) || emu_fell
                          || (|emu_break);
        if (wr_acc && wb_adr_i == ADR_LEVEL) begin
            nxt_st.level_cfg = lvl_merged[15:0] & LEVEL_MASK;
        end
        if (wr_acc && wb_adr_i == ADR_MODE) begin
            nxt_st.mode_edge = mode_merged[N_EXT-1:0];
        end
        // Pending word; mask plays no part here
        pend_now = '0;
        pend_now[BIT_EMU]   = st_ff.emu_pend;
        pend_now[BIT_TICK]  = periodic_tick_pending;
        pend_now[BIT_SPI1]  = spi1_irq;
        for (int i = 0; i < N_EXT; i++) begin
            // Level line follows the pin; source must withdraw to clear
            if (st_ff.mode_edge[i]) begin
                t[0] = st_ff.edge_pend[i];
            end else begin
                t[0] = asserted[i];
            end
            if (i >= 4) begin
                pend_now[BIT_L1 + i - 4] = t[0];
            end else begin
                pend_now[BIT_KEY0 + i] = t[0];
            end
        end
        pend_now[BIT_PWM2]  = pwm2_irq;
        pend_now[BIT_UART2] = uart2_irq;
        pend_now[BIT_PWM1]  = pwm1_irq;
        pend_now[BIT_KB]    = keyboard_pending;
        pend_now[BIT_TIMER_TWO_PENDING]  = timer_two_pending;
        pend_now[BIT_RTC]   = rtc_irq;
        pend_now[BIT_WDT]   = watchdog_pending;
        pend_now[BIT_UART1] = uart1_irq;
        pend_now[BIT_TIMER_ONE_PENDING]  = timer_one_pending;
        pend_now[BIT_SPI2]  = spi2_irq;
        nxt_st.pend = pend_now & PEND_USED;
        // Highest pending level; configurable ones from the level register
        t = 3'h0;
        if (pend_now[BIT_SPI1])  t = lvl_max(t, st_ff.level_cfg[14:12]);
        if (pend_now[BIT_UART2]) t = lvl_max(t, st_ff.level_cfg[10:8]);
        if (pend_now[BIT_PWM2])  t = lvl_max(t, st_ff.level_cfg[6:4]);
        if (pend_now[BIT_TIMER_TWO_PENDING])  t = lvl_max(t, st_ff.level_cfg[2:0]);
        if (|pend_now[BIT_KEY0 +: 4] || |pend_now[BIT_KB:BIT_UART1]
            && (pend_now[BIT_KB] || pend_now[BIT_RTC] || pend_now[BIT_WDT]
                || pend_now[BIT_UART1])) begin
            t = lvl_max(t, LVL_4);
        end
        if (pend_now[BIT_SPI2])  t = lvl_max(t, LVL_4);
        if (pend_now[BIT_L1])    t = lvl_max(t, LVL_1);
        if (pend_now[BIT_L2])    t = lvl_max(t, LVL_3 - 3'h1 + 3'h1);
        if (pend_now[BIT_L3])    t = lvl_max(t, LVL_3);
        if (pend_now[BIT_L5])    t = lvl_max(t, LVL_5);
        if (pend_now[BIT_L6] || pend_now[BIT_PWM1] || pend_now[BIT_TIMER_ONE_PENDING]) begin
            t = lvl_max(t, LVL_6);
        end
        if (pend_now[BIT_EMU])   t = LVL_7;
        nxt_st.top = t;
        // Bus answer one cycle after the request; reads have no side effect
        nxt_st.ack  = req;
        nxt_st.rdat = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADR_PENDING: nxt_st.rdat = st_ff.pend;
                ADR_LEVEL:   nxt_st.rdat = {16'h0000, st_ff.level_cfg};
                ADR_MODE:    nxt_st.rdat = {23'h0, st_ff.mode_edge};
                default:     nxt_st.rdat = '0;
            endcase
        end
    end

    // Level-2 line uses the level-3 code; the two are not kept distinct
    // (level 2 has no code, shares the level-3 slot for ordering)

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff           <= '0;
            st_ff.ext_s1    <= '1;
            st_ff.ext_s2    <= '1;
            st_ff.ext_s3    <= '1;
            st_ff.emu_sync  <= '1;
            st_ff.level_cfg <= LEVEL_RESET;
            st_ff.mode_edge <= MODE_RESET;
            st_ff.pend      <= PEND_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o          = st_ff.rdat;
    assign wb_ack_o          = st_ff.ack;
    assign interrupt_pending = st_ff.pend;
    assign top_level         = st_ff.top;

    // Checks
    sequence s_key_edge(int k);
        st_ff.mode_edge[k] && st_ff.ext_s3[k] && !st_ff.ext_s2[k];
    endsequence

    a_reset_levels: assert property (@(posedge core_clk) $rose(rst_b) |->
        st_ff.level_cfg == LEVEL_RESET) else $error("level reset wrong");
    a_emu_sets: assert property (@(posedge core_clk) disable iff (!rst_b)
        (|emu_break) |=> ##1 interrupt_pending[BIT_EMU]) else $error("emu not pending");
    a_emu_top: assert property (@(posedge core_clk) disable iff (!rst_b)
        interrupt_pending[BIT_EMU] |-> top_level == LVL_7) else $error("emu level");
    a_tick_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        interrupt_pending[BIT_TICK] == $past(periodic_tick_pending)) else $error("tick");
    a_spi1_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        interrupt_pending[BIT_SPI1] == $past(spi1_irq)) else $error("spi1");
    a_resv_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        (interrupt_pending & ~PEND_USED) == 32'h0000_0000) else $error("reserved set");
    a_edge_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_key_edge(8) ##1 (st_ff.mode_edge[8] && !clr_seen) |=>
        st_ff.edge_pend[8]) else $error("edge lost");
    a_lvl_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_acc && wb_adr_i == ADR_LEVEL && wb_sel_i == 4'hf) |=>
        st_ff.level_cfg == ($past(wb_dat_i[15:0]) & LEVEL_MASK)) else $error("lvl wr");
    a_ack_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_edge_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
        (clr_seen && !(st_ff.ext_s3[8] && !st_ff.ext_s2[8])) |=>
        !st_ff.edge_pend[8]) else $error("edge not cleared");

endmodule : ipr_pending

// [rtl/ipr_pkg.sv]
/*
 * Package for the interrupt pending register block: register offsets, bit
 * positions, level codes, reset values and pin synchroniser depth.
 * Assumes a 32-bit classic Wishbone slave port on a 250 MHz core clock.
 */
package ipr_pkg;
    localparam logic [3:0]  ADR_PENDING   = 4'h0;    // Byte offset
    localparam logic [3:0]  ADR_LEVEL     = 4'h4;
    localparam logic [3:0]  ADR_MODE      = 4'h8;    // Edge select per external line
    localparam logic [3:0]  ADR_KEYCLR    = 4'hc;    // Port D edge clear
    localparam int          BIT_EMU       = 23;
    localparam int          BIT_TICK      = 22;
    localparam int          BIT_SPI1      = 21;
    localparam int          BIT_L5        = 20;
    localparam int          BIT_L6        = 19;
    localparam int          BIT_L3        = 18;
    localparam int          BIT_L2        = 17;
    localparam int          BIT_L1        = 16;
    localparam int          BIT_PWM2      = 13;
    localparam int          BIT_UART2     = 12;
    localparam int          BIT_KEY0      = 8;
    localparam int          BIT_PWM1      = 7;
    localparam int          BIT_KB        = 6;
    localparam int          BIT_TIMER_TWO_PENDING      = 5;
    localparam int          BIT_RTC       = 4;
    localparam int          BIT_WDT       = 3;
    localparam int          BIT_UART1     = 2;
    localparam int          BIT_TIMER_ONE_PENDING      = 1;
    localparam int          BIT_SPI2      = 0;
    localparam logic [31:0] PEND_USED     = 32'h00ff_3fff;
    localparam logic [31:0] PEND_RESET    = 32'h0000_0000;
    localparam logic [2:0]  LVL_1         = 3'h1;
    localparam logic [2:0]  LVL_3         = 3'h2;
    localparam logic [2:0]  LVL_4         = 3'h4;
    localparam logic [2:0]  LVL_5         = 3'h5;
    localparam logic [2:0]  LVL_6         = 3'h6;
    localparam logic [2:0]  LVL_7         = 3'h7;
    localparam logic [15:0] LEVEL_RESET   = 16'h6533;
    localparam logic [15:0] LEVEL_MASK    = 16'h7777;
    localparam logic [8:0]  MODE_RESET    = 9'h000;
    localparam int          SYNC_DEPTH    = 3;
    localparam int          N_EXT         = 9;       // l5,l6,l3,l2,l1,key3..key0
endpackage : ipr_pkg

// [sim/interrupt_pending_register_bench.sv]
/*
 * Self-checking bench for the interrupt pending register.
 * Assumes the package, the design and the source model are compiled first.
 */
`timescale 1ns/100ps
`define chk(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module interrupt_pending_register_bench;
    import ipr_pkg::*;
    logic        core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, emu_clear;
    logic        emulator_request_pin_b, periodic_tick_pending, spi1_irq, spi2_irq;
    logic        pwm1_irq, pwm2_irq, uart1_irq, uart2_irq, keyboard_pending, rtc_irq;
    logic        timer_one_pending, timer_two_pending, watchdog_pending, ext_request_l5_b;
    logic        ext_request_l6_b, ext_request_l3_b, ext_request_l2_b, ext_request_l1_b;
    logic [1:0]  emu_break;
    logic [2:0]  top_level;
    logic [3:0]  wb_adr_i, wb_sel_i, key_line_b;
    logic [15:0] lc;
    logic [31:0] wb_dat_i, wb_dat_o, interrupt_pending, raise, rd, want;
    int          errors, total_checks, seed, k;
    int          srcs [14] = '{20, 19, 18, 16, 7, 6, 4, 3, 2, 1, 5, 13, 12, 21};
    logic [2:0]  codes [5] = '{LVL_1, LVL_3, LVL_4, LVL_5, LVL_6};

    ipr_pending   dut (.*);
    ipr_src_model src (.*);

    // Free-running core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Fixed levels, or the programmed field for the four configurable ones
    function automatic logic [2:0] lvl_of(input int b, input logic [15:0] l);
        case (b)
            20: return LVL_5;
            19, 7, 1: return LVL_6;
            18: return LVL_3;
            16: return LVL_1;
            5: return l[2:0];
            13: return l[6:4];
            12: return l[10:8];
            21: return l[14:12];
            default: return LVL_4;
        endcase
    endfunction

    // One classic cycle; request held until ack is seen high
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            end_of_test();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    // Sources move, then the pin synchronisers get time to settle
    task automatic drive(input logic [31:0] r);
        @(posedge core_clk);
        raise <= r;
        repeat (10) @(posedge core_clk);
    endtask

    task automatic see_pend(input logic [31:0] e);
        wb(ADR_PENDING, 1'b0, 32'h0000_0000);
        `chk("pending read", e, rd)
        `chk("pending port", e, interrupt_pending)
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard, about ten times the roughly two thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        end_of_test();
    end

    initial begin
        seed = 68;
        {rst_b, emu_clear, emu_break, wb_cyc_i, wb_stb_i, wb_we_i} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, raise} = '0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        see_pend(32'h0000_0000);
        wb(ADR_LEVEL, 1'b0, 32'h0000_0000);
        `chk("level reset", 32'h0000_6533, rd)
        wb(ADR_MODE, 1'b0, 32'h0000_0000);
        `chk("mode reset", 32'h0000_0000, rd)
        wb(4'h2, 1'b0, 32'h0000_0000);
        `chk("unmapped read", 32'h0000_0000, rd)
        $display("test reset done");
        // Level sources follow their inputs; writes of random data leave them be
        for (int i = 0; i < 40; i++) begin
            want = (i == 0) ? 32'h007f_3fff : $random(seed) & 32'h007f_3fff;
            drive(want);
            see_pend(want);
            wb(ADR_PENDING, 1'b1, $random(seed) & 32'h00ff_3fff);
            see_pend(want);
        end
        drive(32'h0000_0000);
        see_pend(32'h0000_0000);
        $display("test sources done");
        // Each of the five codes LVL_1 to LVL_6 in every configurable field, first pass at reset levels
        lc = 16'h6533;
        for (int p = 0; p < 6; p++) begin
            if (p > 0) begin
                for (int f = 0; f < 4; f++) lc[4*f +: 3] = codes[(p + f) % 5];
                wb(ADR_LEVEL, 1'b1, {16'h0000, lc});
                wb(ADR_LEVEL, 1'b0, 32'h0000_0000);
                `chk("level readback", {16'h0000, lc}, rd)
            end
            for (int s = 0; s < 14; s++) begin
                drive(32'h0000_0001 << srcs[s]);
                `chk("top level", lvl_of(srcs[s], lc), top_level)
            end
        end
        drive(32'h0000_0000);
        $display("test levels done");
        // Edge lines latch, and clear only through their own write
        wb(ADR_MODE, 1'b1, 32'h0000_01ff);
        drive(32'h001f_0f00);
        drive(32'h0000_0000);
        see_pend(32'h001f_0f00);
        wb(ADR_PENDING, 1'b1, 32'h0000_0f00);
        see_pend(32'h001f_0f00);
        wb(ADR_PENDING, 1'b1, 32'h0000_0000);
        see_pend(32'h001f_0f00);
        wb(ADR_PENDING, 1'b1, 32'h0008_0000);
        see_pend(32'h0017_0f00);
        wb(ADR_KEYCLR, 1'b1, 32'h0000_0005);
        see_pend(32'h0017_0a00);
        wb(ADR_PENDING, 1'b1, 32'h0017_0000);
        wb(ADR_KEYCLR, 1'b1, 32'h0000_000a);
        see_pend(32'h0000_0000);
        wb(ADR_MODE, 1'b1, 32'h0000_0000);
        $display("test edges done");
        // Two breakpoints and the pin each raise the emulator bit
        for (k = 0; k < 3; k++) begin
            @(posedge core_clk);
            emu_break <= (k < 2) ? 2'b01 << k : 2'b00;
            raise <= (k == 2) ? 32'h0080_0000 : 32'h0000_0000;
            repeat (4) @(posedge core_clk);
            emu_break <= 2'b00;
            raise <= 32'h0000_0000;
            repeat (8) @(posedge core_clk);
            see_pend(32'h0080_0000);
            `chk("emulator level", LVL_7, top_level)
            emu_clear <= 1'b1;
            @(posedge core_clk);
            emu_clear <= 1'b0;
            repeat (4) @(posedge core_clk);
            see_pend(32'h0000_0000);
        end
        $display("test emulator done");
        end_of_test();
    end
endmodule // interrupt_pending_register_bench

// [sim/ipr_src_model.sv]
/*
 * Model of the peripherals and request pins around the pending register.
 * Assumes the bench sets raise in pending-bit positions; pins idle high.
 */
`timescale 1ns/100ps
module ipr_src_model (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] raise,
    output logic             emulator_request_pin_b,
    output logic             periodic_tick_pending,
    output logic             spi1_irq,
    output logic             spi2_irq,
    output logic             pwm1_irq,
    output logic             pwm2_irq,
    output logic             uart1_irq,
    output logic             uart2_irq,
    output logic             keyboard_pending,
    output logic             timer_one_pending,
    output logic             timer_two_pending,
    output logic             rtc_irq,
    output logic             watchdog_pending,
    output logic             ext_request_l5_b,
    output logic             ext_request_l6_b,
    output logic             ext_request_l3_b,
    output logic             ext_request_l2_b,
    output logic             ext_request_l1_b,
    output logic [3:0]       key_line_b
);
    logic [31:0] cur_ff;

    // Sources move just after the edge, as same-clock peripherals do
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= 32'h0000_0000;
        end else begin
            cur_ff <= raise;
        end
    end

    // Internal sources active high; pins active low, released to the pull-up
    assign emulator_request_pin_b = ~cur_ff[23];
    assign {periodic_tick_pending, spi1_irq} = cur_ff[22:21];
    assign {ext_request_l5_b, ext_request_l6_b, ext_request_l3_b} = ~cur_ff[20:18];
    assign {ext_request_l2_b, ext_request_l1_b} = ~cur_ff[17:16];
    assign {pwm2_irq, uart2_irq} = cur_ff[13:12];
    assign key_line_b = ~cur_ff[11:8];
    assign {pwm1_irq, keyboard_pending, timer_two_pending, rtc_irq} = cur_ff[7:4];
    assign {watchdog_pending, uart1_irq, timer_one_pending, spi2_irq} = cur_ff[3:0];
endmodule // ipr_src_model
